/* File: rtl/indirect_decoder_pkg.sv */
// Operation
// - pointer 0x2000..0x29AF is linear ram window
// - window concatenates 80-byte ram blocks by bank
// - bank's last byte steps to next bank's first
// - common ram never reached through window
// - reads of unimplemented memory return 0x00
// - program flash fills upper pointer half
// - pointer msb set: low 15 bits address flash
// - flash read returns low eight word bits
// - indirect writes never modify program flash
// - flash access takes one extra cycle
package indirect_decoder_pkg;
    localparam logic [15:0] LINEAR_BASE      = 16'h2000;
    localparam logic [15:0] LINEAR_LAST      = 16'h29AF;
    localparam logic [11:0] RAM_BLOCK_BYTES  = 12'h050;
    localparam logic [6:0]  RAM_FIRST_OFFSET = 7'h20;
    localparam logic [6:0]  RAM_LAST_OFFSET  = 7'h6F;
    localparam logic [6:0]  COMMON_FIRST     = 7'h70;
    localparam int          FLASH_MSB        = 15;
    localparam int          FLASH_ADDR_W     = 15;
    localparam int          FLASH_WORD_W     = 14;
    localparam logic [7:0]  UNIMPL_READ      = 8'h00;
    localparam logic [4:0]  IMPL_BANKS       = 5'h02;
    localparam int          FLASH_EXTRA      = 1;

    typedef enum logic [2:0] {
        TGT_NONE  = 3'b001,
        TGT_RAM   = 3'b010,
        TGT_FLASH = 3'b100
    } target_e;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_RAM   = 4'b0010,
        ST_FLASH = 4'b0100,
        ST_DONE  = 4'b1000
    } state_e;
endpackage

/* File: rtl/decode_if.sv */
`timescale 1ns/1ps
interface decode_if;
    import indirect_decoder_pkg::*;
    logic [15:0]             pointer;
    target_e                 target;
    logic [4:0]              bank;
    logic [6:0]              bank_offset;
    logic [FLASH_ADDR_W-1:0] flash_addr;
    modport decoder (input pointer, output target, output bank, output bank_offset, output flash_addr);
    modport user    (output pointer, input target, input bank, input bank_offset, input flash_addr);
endinterface

/* File: rtl/pointer_decode.sv */
`timescale 1ns/1ps
module pointer_decode (
    decode_if.decoder dec
);
    import indirect_decoder_pkg::*;
    logic [11:0] lin_off;
    logic [11:0] lin_bank;
    logic [11:0] lin_rem;

    assign lin_off  = 12'(dec.pointer - LINEAR_BASE);
    assign lin_bank = lin_off / RAM_BLOCK_BYTES;
    assign lin_rem  = lin_off % RAM_BLOCK_BYTES;
    assign dec.flash_addr = dec.pointer[FLASH_ADDR_W-1:0];

    always_comb begin
        dec.target      = TGT_NONE;
        dec.bank        = dec.pointer[11:7];
        dec.bank_offset = dec.pointer[6:0];
        if (dec.pointer[FLASH_MSB]) begin
            dec.target = TGT_FLASH;
        end else if (dec.pointer >= LINEAR_BASE && dec.pointer <= LINEAR_LAST) begin
            // remainder never reaches common, so window skips it
            dec.bank        = lin_bank[4:0];
            dec.bank_offset = 7'(lin_rem) + RAM_FIRST_OFFSET;
            dec.target      = (lin_bank[4:0] < IMPL_BANKS) ? TGT_RAM : TGT_NONE;
        end else if (dec.pointer < LINEAR_BASE) begin
            // common ram is in every bank; banked gpr only where implemented
            if (dec.pointer[6:0] >= COMMON_FIRST) begin
                dec.target = TGT_RAM;
            end else if (dec.pointer[6:0] >= RAM_FIRST_OFFSET && dec.pointer[6:0] <= RAM_LAST_OFFSET
                         && dec.pointer[11:7] < IMPL_BANKS && dec.pointer[12] == 1'b0) begin
                dec.target = TGT_RAM;
            end
        end
    end
endmodule

/* File: rtl/indirect_address_decoder.sv */
`timescale 1ns/1ps
module indirect_address_decoder (
    input  wire logic                                     clk_sys,
    input  wire logic                                     resetn,
    input  wire logic                                     req,
    input  wire logic                                     req_write,
    input  wire logic [15:0]                              indirect_pointer,
    input  wire logic [7:0]                               write_data,
    output logic      [7:0]                               read_data,
    output logic                                          ack,
    output logic                                          busy,
    output logic                                          ram_read,
    output logic                                          ram_write,
    output logic      [4:0]                               ram_bank,
    output logic      [6:0]                               ram_offset,
    output logic      [7:0]                               ram_wdata,
    input  wire logic [7:0]                               ram_rdata,
    output logic                                          flash_read,
    output logic      [indirect_decoder_pkg::FLASH_ADDR_W-1:0] flash_addr,
    input  wire logic [indirect_decoder_pkg::FLASH_WORD_W-1:0] flash_rdata
);
    import indirect_decoder_pkg::*;

    decode_if dec ();
    state_e   state;
    logic     take;
    logic     flash_wait;
    logic     hit_ram;
    logic     hit_flash;
    logic     hit_none;
    logic     flash_last;

    assign dec.pointer = indirect_pointer;
    assign take        = req && state == ST_IDLE;
    assign hit_ram     = dec.target == TGT_RAM;
    assign hit_flash   = dec.target == TGT_FLASH;
    assign hit_none    = dec.target == TGT_NONE;
    assign flash_last  = state == ST_FLASH && flash_wait;

    pointer_decode u_decode (
        .dec (dec)
    );

    // request is refused while busy; core must hold off
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (req) begin
                        unique case (dec.target)
                            TGT_RAM:   state <= ST_RAM;
                            TGT_FLASH: state <= ST_FLASH;
                            TGT_NONE:  state <= ST_DONE;
                            default:   state <= ST_DONE;
                        endcase
                    end
                end
                ST_RAM: begin
                    state <= ST_DONE;
                end
                ST_FLASH: begin
                    // extra cycle lets flash data settle
                    if (flash_wait) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // marks the second flash cycle; cleared whenever idle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flash_wait <= 1'b0;
        end else if (state == ST_IDLE) begin
            flash_wait <= 1'b0;
        end else if (state == ST_FLASH) begin
            flash_wait <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ram_read <= 1'b0;
        end else begin
            ram_read <= take && hit_ram && !req_write;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ram_write <= 1'b0;
        end else begin
            ram_write <= take && hit_ram && req_write;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ram_bank <= 5'h00;
        end else if (take) begin
            ram_bank <= dec.bank;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ram_offset <= 7'h00;
        end else if (take) begin
            ram_offset <= dec.bank_offset;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ram_wdata <= 8'h00;
        end else if (take) begin
            ram_wdata <= write_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flash_read <= 1'b0;
        end else begin
            // writes to flash are dropped, only reads strobe it
            flash_read <= (take && hit_flash && !req_write) || (flash_read && !flash_wait);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flash_addr <= '0;
        end else if (take) begin
            flash_addr <= dec.flash_addr;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ack <= 1'b0;
        end else begin
            ack <= (state == ST_RAM) || flash_last || (take && hit_none);
        end
    end

    // ack, not busy, marks completion; busy drops as ack rises for ram and flash
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
        end else begin
            busy <= take || (state == ST_FLASH && !flash_wait);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            read_data <= 8'h00;
        end else if (take && hit_none) begin
            read_data <= UNIMPL_READ;
        end else if (state == ST_RAM) begin
            read_data <= ram_read ? ram_rdata : 8'h00;
        end else if (flash_last) begin
            read_data <= flash_read ? flash_rdata[7:0] : 8'h00;
        end
    end
endmodule

/* File: verification/indirect_address_decoder_monitor.sv */
`timescale 1ns/1ps
module indirect_address_decoder_monitor (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        req,
    input wire logic        req_write,
    input wire logic [15:0] indirect_pointer,
    input wire logic [7:0]  write_data,
    input wire logic [7:0]  read_data,
    input wire logic        ack,
    input wire logic        busy,
    input wire logic        ram_read,
    input wire logic        ram_write,
    input wire logic [4:0]  ram_bank,
    input wire logic [6:0]  ram_offset,
    input wire logic [7:0]  ram_wdata,
    input wire logic [7:0]  ram_rdata,
    input wire logic        flash_read,
    input wire logic [14:0] flash_addr,
    input wire logic [13:0] flash_rdata
);
    logic        pend;
    logic        rd_q;
    logic [15:0] lo;
    // decoder stays out of idle through the ack cycle, so only a free slot takes
    wire take = req && !pend;
    wire lin  = indirect_pointer >= 16'h2000 && indirect_pointer <= 16'h29AF;
    wire impl = lin && lo < 16'h00A0;
    assign lo = indirect_pointer - 16'h2000;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pend <= 1'b0;
            rd_q <= 1'b0;
        end else if (take) begin
            pend <= 1'b1;
            rd_q <= !req_write;
        end else if (ack) begin
            pend <= 1'b0;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    window_map_a: assert property (take && impl |=> ram_bank == 5'($past(lo) / 16'h0050) &&
        ram_offset == 7'($past(lo) % 16'h0050 + 16'h0020)) else $error("linear mapping wrong");
    ram_cycle_a: assert property (take && impl |=> (ram_read ^ ram_write) ##1 ack) else $error("ram timing wrong");
    no_common_a: assert property (take && lin |=> !(ram_read || ram_write) ||
        ram_offset inside {[7'h20:7'h6F]}) else $error("window reached common ram");
    unimpl_zero_a: assert property (take && !req_write && (lin && !impl || indirect_pointer inside
        {[16'h29B0:16'h7FFF]}) |=> ack && read_data == 8'h00) else $error("unimplemented read not zero");
    flash_addr_a: assert property (take && indirect_pointer[15] |=> flash_read == $past(!req_write) &&
        flash_addr == $past(indirect_pointer[14:0])) else $error("flash address wrong");
    flash_extra_a: assert property (take && indirect_pointer[15] |=> !ack ##1 !ack ##1 ack) else $error("flash latency");
    flash_byte_a: assert property (flash_read ##1 flash_read && rd_q |=> ack &&
        read_data == $past(flash_rdata[7:0])) else $error("flash byte wrong");
    flash_nowr_a: assert property (take && indirect_pointer[15] |=> !ram_write [*3]) else $error("flash write leaked");
    ram_data_a: assert property (ram_read |=> ack && read_data == $past(ram_rdata)) else $error("ram data wrong");
    ram_wdata_a: assert property (take && impl && req_write |=> ram_write &&
        ram_wdata == $past(write_data)) else $error("ram write data wrong");
    busy_take_a: assert property (take |=> busy) else $error("busy missing after take");
    cover property (take && impl);
    cover property (take && indirect_pointer[15] && req_write);
    cover property (ack && rd_q && read_data == 8'h00);
    cover property (take && indirect_pointer[15] && !req_write);
endmodule

/* File: verification/mem_model.sv */
`timescale 1ns/1ps
module mem_model (
    input  wire logic        clk_sys,
    input  wire logic        ram_read,
    input  wire logic        ram_write,
    input  wire logic [4:0]  ram_bank,
    input  wire logic [6:0]  ram_offset,
    input  wire logic [7:0]  ram_wdata,
    output logic      [7:0]  ram_rdata,
    input  wire logic        flash_read,
    input  wire logic [14:0] flash_addr,
    output logic      [13:0] flash_rdata
);
    logic [7:0]  ram [0:255];
    logic [13:0] junk = 14'h0000;
    always @(posedge clk_sys) begin
        junk <= junk + 14'h1357;
        if (ram_write) begin
            ram[{ram_bank[0], ram_offset}] <= ram_wdata;
        end
    end
    // idle lines churn so a late sample never sees stale data
    assign ram_rdata   = ram_read ? ram[{ram_bank[0], ram_offset}] : ~junk[7:0];
    // upper word bits differ from the low byte; no write path at all
    assign flash_rdata = flash_read ? {flash_addr[5:0], flash_addr[7:0] ^ 8'hA5} : junk;
endmodule

/* File: verification/indirect_address_decoder_test.sv */
`timescale 1ns/1ps
module indirect_address_decoder_test;
    logic        clk_sys = 1'b0, resetn = 1'b0, req = 1'b0, req_write = 1'b0, ack, busy;
    logic        ram_read, ram_write, flash_read;
    logic [15:0] indirect_pointer = 16'h0000;
    logic [7:0]  write_data = 8'h00, read_data, ram_wdata, ram_rdata, rd;
    logic [4:0]  ram_bank;
    logic [6:0]  ram_offset;
    logic [14:0] flash_addr;
    logic [13:0] flash_rdata;
    int          mismatches = 0, n_tests = 0, cyc = 0, lat;
    always #25 clk_sys = ~clk_sys;
    indirect_address_decoder u_dut (
        .clk_sys          (clk_sys),
        .resetn           (resetn),
        .req              (req),
        .req_write        (req_write),
        .indirect_pointer (indirect_pointer),
        .write_data       (write_data),
        .read_data        (read_data),
        .ack              (ack),
        .busy             (busy),
        .ram_read         (ram_read),
        .ram_write        (ram_write),
        .ram_bank         (ram_bank),
        .ram_offset       (ram_offset),
        .ram_wdata        (ram_wdata),
        .ram_rdata        (ram_rdata),
        .flash_read       (flash_read),
        .flash_addr       (flash_addr),
        .flash_rdata      (flash_rdata)
    );
    mem_model u_mem (
        .clk_sys     (clk_sys),
        .ram_read    (ram_read),
        .ram_write   (ram_write),
        .ram_bank    (ram_bank),
        .ram_offset  (ram_offset),
        .ram_wdata   (ram_wdata),
        .ram_rdata   (ram_rdata),
        .flash_read  (flash_read),
        .flash_addr  (flash_addr),
        .flash_rdata (flash_rdata)
    );
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 400) begin
            mismatches++;
            final_report();
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // core side: hold request one cycle past the sampled ack, then idle one cycle
    task automatic acc(input logic w, input logic [15:0] p, input logic [7:0] d, input logic [7:0] n);
        req = 1'b1;
        req_write = w;
        indirect_pointer = p;
        write_data = d;
        lat = 0;
        do begin
            @(negedge clk_sys);
            lat++;
        end while (ack !== 1'b1 && lat < 8);
        rd = read_data;
        chk(8'(lat), n);
        @(negedge clk_sys);
        req = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic t_ram;
        acc(1'b1, 16'h204F, 8'h5A, 8'h02);
        acc(1'b1, 16'h2050, 8'hC3, 8'h02);
        acc(1'b1, 16'h0070, 8'h77, 8'h02);
        acc(1'b1, 16'h209F, 8'h11, 8'h02);
        acc(1'b0, 16'h204F, 8'h00, 8'h02);
        chk(rd, 8'h5A);
        acc(1'b0, 16'h00A0, 8'h00, 8'h02);
        chk(rd, 8'hC3);
        acc(1'b0, 16'h0070, 8'h00, 8'h02);
        chk(rd, 8'h77);
        acc(1'b0, 16'h00EF, 8'h00, 8'h02);
        chk(rd, 8'h11);
    endtask
    task automatic t_unimpl;
        logic [15:0] p [4] = '{16'h20A0, 16'h29AF, 16'h29B0, 16'h7FFF};
        acc(1'b1, 16'h29B0, 8'hEE, 8'h01);
        foreach (p[i]) begin
            acc(1'b0, p[i], 8'h00, 8'h01);
            chk(rd, 8'h00);
        end
    endtask
    // a leaked flash write would land on common byte 0x00FF in the model
    task automatic t_flash;
        acc(1'b0, 16'h8123, 8'h00, 8'h03);
        chk(rd, 8'h86);
        acc(1'b1, 16'h00FF, 8'hA7, 8'h02);
        acc(1'b1, 16'hFFFF, 8'h3C, 8'h03);
        acc(1'b0, 16'hFFFF, 8'h00, 8'h03);
        chk(rd, 8'h5A);
        acc(1'b0, 16'h00FF, 8'h00, 8'h02);
        chk(rd, 8'hA7);
    endtask
    initial begin
        repeat (8) @(negedge clk_sys);
        resetn = 1'b1;
        t_ram();
        t_unimpl();
        t_flash();
        final_report();
    end
endmodule
bind indirect_address_decoder indirect_address_decoder_monitor u_mon (
    .clk_sys          (clk_sys),
    .resetn           (resetn),
    .req              (req),
    .req_write        (req_write),
    .indirect_pointer (indirect_pointer),
    .write_data       (write_data),
    .read_data        (read_data),
    .ack              (ack),
    .busy             (busy),
    .ram_read         (ram_read),
    .ram_write        (ram_write),
    .ram_bank         (ram_bank),
    .ram_offset       (ram_offset),
    .ram_wdata        (ram_wdata),
    .ram_rdata        (ram_rdata),
    .flash_read       (flash_read),
    .flash_addr       (flash_addr),
    .flash_rdata      (flash_rdata)
);
